/* File: verification/adc_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_chk (
	input wire logic        clock_in,
	input wire logic        reset_n_in,
	input wire logic [1:0]  reg_addr_in,
	input wire logic [7:0]  reg_wdata_in,
	input wire logic        reg_write_in,
	input wire logic        reg_read_in,
	input wire logic [7:0]  reg_rdata_out,
	input wire logic        sample_valid_out,
	input wire logic [2:0]  sample_chan_out,
	input wire logic [15:0] sample_word_out,
	input wire logic        mod_strobe_out,
	input wire logic        ref_output_enable_out,
	input wire logic        fifo_overrun_out
);
	logic [1:0] mode;
	default clocking @(posedge clock_in); endclocking
	default disable iff (!reset_n_in);
	// mode mirror; the bench drains the fifo before each change into data or mixed mode
	always_ff @(posedge clock_in or negedge reset_n_in)
		if (!reset_n_in)
			mode <= 2'h0;
		else if (reg_write_in && reg_addr_in == 2'h0)
			mode <= reg_wdata_in[1:0];
	sequence s_strobe_gap;
		!mod_strobe_out [*7] ##1 mod_strobe_out;
	endsequence
	sequence s_ref_write;
		reg_write_in && reg_addr_in == 2'h2;
	endsequence
	a_strobe_period: assert property (mod_strobe_out |=> s_strobe_gap)
		else $error("modulator strobe spacing wrong");
	a_valid_pulse: assert property (sample_valid_out |=> !sample_valid_out)
		else $error("sample valid longer than one cycle");
	a_chan_range: assert property (sample_valid_out |-> sample_chan_out < 3'h6)
		else $error("sample channel out of range");
	a_data_lsb: assert property (sample_valid_out && mode == 2'h1 |-> !sample_word_out[0] || sample_word_out == 16'h7fff)
		else $error("data mode low bit set");
	a_mix_flag: assert property (sample_valid_out && mode == 2'h3 |-> !sample_word_out[15])
		else $error("mixed mode flag bit set on sample");
	a_ref_follow: assert property (s_ref_write |-> ##2 ref_output_enable_out == $past(reg_wdata_in[6], 2))
		else $error("reference enable does not follow bit 6");
	a_read_idle: assert property (!reg_read_in |=> reg_rdata_out == 8'h00)
		else $error("read data without read strobe");
	a_overrun_sticky: assert property (fifo_overrun_out |=> fifo_overrun_out)
		else $error("overrun flag cleared");
endmodule // adc_chk
`default_nettype wire

/* File: verification/adc_decimator_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_decimator_tb;
	typedef struct {logic [1:0] mode; logic [1:0] rate; logic [15:0] word; int period;} adc_row_t;
	logic        clock_in = 0, reset_n_in = 0, reg_write_in = 0, reg_read_in = 0, stall = 0;
	logic [1:0]  reg_addr_in = 2'h0;
	logic [7:0]  reg_wdata_in = 8'h00, rd, reg_rdata_out;
	logic [5:0]  mod_bits_in = 6'h00;
	logic        sample_valid_out, sample_ready_in, mod_strobe_out, ref_output_enable_out, fifo_overrun_out;
	logic [2:0]  sample_chan_out;
	logic [15:0] sample_word_out, last0;
	logic [17:0] gain_code_out;
	logic [47:0] gain_db_out;
	int          errors = 0, n_compared = 0, cyc = 0, n_words, gap0, snap;
	adc_row_t    rows [4] = '{'{2'h3, 2'h0, 16'h3fff, 2048}, '{2'h1, 2'h3, 16'h7fff, 256},
		'{2'h3, 2'h2, 16'h3fff, 512}, '{2'h1, 2'h1, 16'h7fff, 1024}};
	logic [7:0]  db [8] = '{8'h00, 8'h06, 8'h0c, 8'h12, 8'h14, 8'h1a, 8'h20, 8'h26};
	adc_decimator u_adc_decimator (.clock_in(clock_in), .reset_n_in(reset_n_in), .mod_bits_in(mod_bits_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
		.reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out), .sample_valid_out(sample_valid_out),
		.sample_chan_out(sample_chan_out), .sample_word_out(sample_word_out), .sample_ready_in(sample_ready_in),
		.mod_strobe_out(mod_strobe_out), .gain_code_out(gain_code_out), .gain_db_out(gain_db_out),
		.ref_output_enable_out(ref_output_enable_out), .fifo_overrun_out(fifo_overrun_out));
	adc_host u_adc_host (.clock_in(clock_in), .stall_in(stall), .valid_in(sample_valid_out),
		.chan_in(sample_chan_out), .word_in(sample_word_out), .ready_out(sample_ready_in),
		.n_words(n_words), .gap0(gap0), .last0(last0));
	always #10 clock_in = ~clock_in;
	task automatic wrap_up;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clock_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_write_in <= 1'b1;
		@(posedge clock_in);
		reg_write_in <= 1'b0;
	endtask
	task automatic rdr(input logic [1:0] a);
		@(posedge clock_in);
		reg_addr_in <= a;
		reg_read_in <= 1'b1;
		@(posedge clock_in);
		reg_read_in <= 1'b0;
		#1 rd = reg_rdata_out;
	endtask
	always @(posedge clock_in) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			errors++;
			wrap_up();
		end
	end
	initial begin
		repeat (16) @(posedge clock_in);
		reset_n_in <= 1'b1;
		mod_bits_in <= 6'h3f;
		@(posedge clock_in);
		chk({ref_output_enable_out, fifo_overrun_out, sample_valid_out}, 16'h0000);
		chk(gain_code_out[15:0], 16'h0000);
		for (int i = 0; i < 4; i++) begin
			wr(2'h0, 8'h00);
			repeat (64) @(posedge clock_in);
			wr(2'h1, {6'h00, rows[i].rate});
			wr(2'h0, {6'h00, rows[i].mode});
			repeat (5 * rows[i].period) @(posedge clock_in);
			// start the count window on a channel 0 word so that no burst is split
			@(posedge clock_in iff (sample_valid_out && sample_ready_in && sample_chan_out == 3'h0));
			snap = n_words;
			chk(last0, rows[i].word);
			chk(gap0[15:0], rows[i].period[15:0]);
			repeat (rows[i].period) @(posedge clock_in);
			chk(n_words - snap, 16'h0006);
		end
		// channels 0 and 1 are both written twice, once via the wrap
		for (int c = 0; c < 8; c++) begin
			wr(2'h3, {1'b0, 3'(c % 6), 1'b0, 3'(c)});
			repeat (4) @(posedge clock_in);
			chk(gain_db_out[8 * (c % 6) +: 8], db[c]);
			chk(gain_code_out[3 * (c % 6) +: 3], c[2:0]);
		end
		wr(2'h2, 8'h40);
		repeat (3) @(posedge clock_in);
		chk(ref_output_enable_out, 16'h0001);
		wr(2'h2, 8'hbf);
		repeat (3) @(posedge clock_in);
		chk(ref_output_enable_out, 16'h0000);
		wr(2'h1, 8'h03);
		wr(2'h0, 8'h02);
		repeat (64) @(posedge clock_in);
		snap = n_words;
		repeat (600) @(posedge clock_in);
		chk(n_words - snap, 16'h0000);
		mod_bits_in <= 6'h2a;
		stall <= 1'b1;
		wr(2'h0, 8'h01);
		repeat (900) @(posedge clock_in);
		snap = n_words;
		repeat (300) @(posedge clock_in);
		chk(n_words - snap, 16'h0000);
		rdr(2'h3);
		chk(rd[3], 16'h0001);
		stall <= 1'b0;
		repeat (1200) @(posedge clock_in);
		chk(last0[0], 16'h0000);
		chk(n_words > snap, 16'h0001);
		wrap_up();
	end
endmodule // adc_decimator_tb
bind adc_decimator adc_chk u_adc_chk (.clock_in(clock_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
	.reg_rdata_out(reg_rdata_out), .sample_valid_out(sample_valid_out), .sample_chan_out(sample_chan_out),
	.sample_word_out(sample_word_out), .mod_strobe_out(mod_strobe_out),
	.ref_output_enable_out(ref_output_enable_out), .fifo_overrun_out(fifo_overrun_out));
`default_nettype wire

/* File: verification/adc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_host (
	input wire logic        clock_in,
	input wire logic        stall_in,
	input wire logic        valid_in,
	input wire logic [2:0]  chan_in,
	input wire logic [15:0] word_in,
	output logic            ready_out,
	output var int          n_words,
	output var int          gap0,
	output logic [15:0]     last0
);
	int t, t0;
	initial begin
		t = 0;
		t0 = 0;
		n_words = 0;
		gap0 = 0;
		last0 = 16'h0000;
	end
	// a busy host simply holds ready low
	assign ready_out = !stall_in;
	always @(posedge clock_in) begin
		t <= t + 1;
		if (valid_in && ready_out) begin
			n_words <= n_words + 1;
			if (chan_in == 3'h0) begin
				last0 <= word_in;
				gap0 <= t - t0;
				t0 <= t;
			end
		end
	end
endmodule // adc_host
`default_nettype wire

/* File: verilog/adc_consts.vh */
// Notes on behaviour
// R1: six independent channels, each with its own stream and filter, sampled on one shared schedule.
// R2: each modulator bit arrives once per eight internal master clock periods.
// R3: the filter is a third-order sinc, the cube of a 32-tap moving sum.
// R4: the filter decimates by 32 to one 15-bit word per master-clock/256 period.
// R5: the pipeline latency keeps the group delay near 25 microseconds.
// R6: every result is two's complement.
// R7: in 16-bit data mode the result is shifted left by one with a zero in the low bit.
// R8: in 16-bit data mode a result at or above positive full scale gives exactly 0x7fff.
// R9: in mixed mode the result keeps 15 bits and the top bit flags control or sample content.
// R10: a 3-bit gain code selects 0, 6, 12, 18, 20, 26, 32 or 38 dB.
// R11: the buffered reference output is enabled only while bit 6 of the reference control register is set.
// R12: mode bit 0 clear is control mode, bit 0 alone is data mode, bits 0 and 1 give mixed mode.
// R13: a 2-bit field picks master clock over 2048, 1024, 512 or 256, with 2048 after reset.
// R14: accumulators are wide enough never to overflow and the result saturates to signed 15 bits.
`ifndef ADC_CONSTS_VH
`define ADC_CONSTS_VH
`define ADC_CHANNELS       6
`define ADC_MOD_DIV        8
`define ADC_DECIM          32
`define ADC_RES_BITS       15
`define ADC_ACC_BITS       16
`define ADC_GROUP_DELAY_US 25
`define ADC_CLK_MHZ        50
`define ADC_ADDR_MODE      2'h0
`define ADC_ADDR_RATE      2'h1
`define ADC_ADDR_REF       2'h2
`define ADC_ADDR_GAIN      2'h3
`define ADC_REF_EN_BIT     6
`define ADC_MODE_DATA_BIT  0
`define ADC_MODE_MIX_BIT   1
`define ADC_RATE_RESET     2'h0
`define ADC_POS_FULL       16'h7fff
`define ADC_FIFO_DEPTH     16
`endif

/* File: verilog/adc_decimator.v */
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "adc_consts.vh"
module adc_decimator #(
	parameter CHANNELS = 6,
	parameter MCLK_DIV = 1
) (
	input  wire                  clock_in,
	input  wire                  reset_n_in,
	input  wire [CHANNELS-1:0]   mod_bits_in,
	input  wire [1:0]            reg_addr_in,
	input  wire [7:0]            reg_wdata_in,
	input  wire                  reg_write_in,
	input  wire                  reg_read_in,
	output reg  [7:0]            reg_rdata_out,
	output reg                   sample_valid_out,
	output reg  [2:0]            sample_chan_out,
	output reg  [15:0]           sample_word_out,
	input  wire                  sample_ready_in,
	output reg                   mod_strobe_out,
	output reg  [3*CHANNELS-1:0] gain_code_out,
	output reg  [8*CHANNELS-1:0] gain_db_out,
	output reg                   ref_output_enable_out,
	output reg                   fifo_overrun_out
);
	// sinc3 of length 32 grows 3*log2(32)=15 bits; three extra guard the signed range
	localparam AB = `ADC_ACC_BITS + 2;
	localparam ST_IDLE = 2'h0;
	localparam ST_PUSH = 2'h1;
	reg [7:0]            serial_mode_control_reg;
	reg [1:0]            clock_rate_control_reg;
	reg [7:0]            ref_power_reg;
	reg [3*CHANNELS-1:0] gain_reg;
	reg [15:0]           clk_div;
	reg [2:0]            mod_div;
	reg [4:0]            dec_cnt;
	reg [2:0]            out_cnt;
	reg                  mod_tick;
	reg                  dec_tick;
	reg [1:0]            push_state;
	reg [2:0]            push_chan;
	reg [CHANNELS-1:0]   pending;
	reg [16*CHANNELS-1:0] result_bus;
	wire [AB*CHANNELS-1:0] comb_bus;
	wire                 int_mclk_tick;
	wire                 fifo_in_ready;
	wire                 fifo_out_valid;
	wire [18:0]          fifo_out_data;
	wire                 out_rate_hit;
	wire [1:0]           fmt_mode;
	assign int_mclk_tick = (clk_div == MCLK_DIV - 1);
	assign fmt_mode = serial_mode_control_reg[1:0];
	// R13 rate select
	assign out_rate_hit = (clock_rate_control_reg == 2'h3) ? 1'b1 :
		(clock_rate_control_reg == 2'h2) ? (out_cnt[0] == 1'b1) :
		(clock_rate_control_reg == 2'h1) ? (out_cnt[1:0] == 2'h3) : (out_cnt == 3'h7);
	always @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			clk_div <= 16'h0000;
			mod_div <= 3'h0;
			dec_cnt <= 5'h00;
			out_cnt <= 3'h0;
			mod_tick <= 1'b0;
			dec_tick <= 1'b0;
			mod_strobe_out <= 1'b0;
		end else begin
			mod_tick <= 1'b0;
			dec_tick <= 1'b0;
			clk_div <= int_mclk_tick ? 16'h0000 : clk_div + 16'h0001;
			// R2 one bit per eight master clocks
			if (int_mclk_tick) begin
				mod_div <= mod_div + 3'h1;
				if (mod_div == `ADC_MOD_DIV - 1) begin
					mod_tick <= 1'b1;
					// R4 decimate by 32
					dec_cnt <= dec_cnt + 5'h01;
					if (dec_cnt == `ADC_DECIM - 1) begin
						out_cnt <= out_cnt + 3'h1;
						dec_tick <= out_rate_hit;
					end
				end
			end
			mod_strobe_out <= int_mclk_tick & (mod_div == `ADC_MOD_DIV - 1);
		end
	end
	genvar g;
	generate
		// R1 one filter per channel
		for (g = 0; g < CHANNELS; g = g + 1) begin : chan
			reg signed [AB-1:0] i1, i2, i3, c1d, c2d, c3d, c1, c2, c3;
			wire signed [AB-1:0] x = mod_bits_in[g] ? 18'sd1 : -18'sd1;
			// R3 cascaded integrators then combs at the decimated rate, once per 32 modulator bits
			always @(posedge clock_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					i1 <= 0; i2 <= 0; i3 <= 0;
				end else if (mod_tick) begin
					i1 <= i1 + x;
					i2 <= i2 + i1;
					i3 <= i3 + i2;
				end
			end
			// R5 single decimated stage keeps latency short
			always @(posedge clock_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					c1d <= 0; c2d <= 0; c3d <= 0; c1 <= 0; c2 <= 0; c3 <= 0;
				end else if (mod_tick && dec_cnt == 5'h00) begin
					c1  <= i3 - c1d;
					c1d <= i3;
					c2  <= (i3 - c1d) - c2d;
					c2d <= i3 - c1d;
					c3  <= ((i3 - c1d) - c2d) - c3d;
					c3d <= (i3 - c1d) - c2d;
				end
			end
			assign comb_bus[AB*g +: AB] = c3 >>> 1;
		end
	endgenerate
	// R14 saturate to signed 15 bits
	function [14:0] sat15;
		input [AB-1:0] v;
		begin
			if (!v[AB-1] && v[AB-2:14] != 0)
				sat15 = 15'h3fff;
			else if (v[AB-1] && ~v[AB-2:14] != 0)
				sat15 = 15'h4000;
			else
				sat15 = v[14:0];
		end
	endfunction
	// R6 R7 R8 R9 word formatting
	function [15:0] fmt_word;
		input [14:0] r;
		input [1:0]  m;
		begin
			if (m[`ADC_MODE_DATA_BIT] && m[`ADC_MODE_MIX_BIT])
				fmt_word = {1'b0, r};
			else if (r == 15'h3fff)
				fmt_word = `ADC_POS_FULL;
			else
				fmt_word = {r, 1'b0};
		end
	endfunction
	integer k;
	always @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			result_bus <= {(16*CHANNELS){1'b0}};
			pending <= {CHANNELS{1'b0}};
			push_state <= ST_IDLE;
			push_chan <= 3'h0;
			fifo_overrun_out <= 1'b0;
		end else begin
			case (push_state)
				ST_IDLE: begin
					// R12 control mode pushes nothing
					if (dec_tick && serial_mode_control_reg[`ADC_MODE_DATA_BIT]) begin
						for (k = 0; k < CHANNELS; k = k + 1)
							result_bus[16*k +: 16] <= fmt_word(sat15(comb_bus[AB*k +: AB]), fmt_mode);
						pending <= {CHANNELS{1'b1}};
						push_chan <= 3'h0;
						push_state <= ST_PUSH;
					end
				end
				ST_PUSH: begin
					if (fifo_in_ready) begin
						pending[push_chan] <= 1'b0;
						push_chan <= push_chan + 3'h1;
						if (push_chan == CHANNELS - 1)
							push_state <= ST_IDLE;
					end
					// new sample while still pushing is dropped and sets the overrun flag
					if (dec_tick)
						fifo_overrun_out <= 1'b1;
				end
				default: push_state <= ST_IDLE;
			endcase
		end
	end
	adc_fifo #(
		.WIDTH(19),
		.DEPTH(`ADC_FIFO_DEPTH),
		.AW(4)
	) u_fifo (
		.clock_in(clock_in),
		.reset_n_in(reset_n_in),
		.in_valid_in(push_state == ST_PUSH),
		.in_ready_out(fifo_in_ready),
		.in_data_in({push_chan, result_bus[16*push_chan +: 16]}),
		.out_valid_out(fifo_out_valid),
		.out_ready_in(sample_ready_in & ~sample_valid_out),
		.out_data_out(fifo_out_data)
	);
	always @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sample_valid_out <= 1'b0;
			sample_chan_out <= 3'h0;
			sample_word_out <= 16'h0000;
		end else if (sample_valid_out) begin
			sample_valid_out <= 1'b0;
		end else if (fifo_out_valid && sample_ready_in) begin
			sample_valid_out <= 1'b1;
			sample_chan_out <= fifo_out_data[18:16];
			sample_word_out <= fifo_out_data[15:0];
		end
	end
	// R10 gain code to dB
	function [7:0] gain_db;
		input [2:0] c;
		begin
			case (c)
				3'h0: gain_db = 8'h00;
				3'h1: gain_db = 8'h06;
				3'h2: gain_db = 8'h0c;
				3'h3: gain_db = 8'h12;
				3'h4: gain_db = 8'h14;
				3'h5: gain_db = 8'h1a;
				3'h6: gain_db = 8'h20;
				default: gain_db = 8'h26;
			endcase
		end
	endfunction
	integer j;
	always @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			serial_mode_control_reg <= 8'h00;
			clock_rate_control_reg <= `ADC_RATE_RESET;
			ref_power_reg <= 8'h00;
			gain_reg <= {(3*CHANNELS){1'b0}};
			reg_rdata_out <= 8'h00;
			gain_code_out <= {(3*CHANNELS){1'b0}};
			gain_db_out <= {(8*CHANNELS){1'b0}};
			ref_output_enable_out <= 1'b0;
		end else begin
			if (reg_write_in) begin
				case (reg_addr_in)
					`ADC_ADDR_MODE: serial_mode_control_reg <= {6'h00, reg_wdata_in[1:0]};
					`ADC_ADDR_RATE: clock_rate_control_reg <= reg_wdata_in[1:0];
					`ADC_ADDR_REF:  ref_power_reg <= reg_wdata_in;
					default: gain_reg[3*reg_wdata_in[6:4] +: 3] <= reg_wdata_in[2:0];
				endcase
			end
			reg_rdata_out <= 8'h00;
			if (reg_read_in) begin
				case (reg_addr_in)
					`ADC_ADDR_MODE: reg_rdata_out <= serial_mode_control_reg;
					`ADC_ADDR_RATE: reg_rdata_out <= {6'h00, clock_rate_control_reg};
					`ADC_ADDR_REF:  reg_rdata_out <= ref_power_reg;
					default: reg_rdata_out <= {fifo_overrun_out, 3'h0, fifo_out_valid, pending[2:0]};
				endcase
			end
			// R11 reference enable bit
			ref_output_enable_out <= ref_power_reg[`ADC_REF_EN_BIT];
			gain_code_out <= gain_reg;
			for (j = 0; j < CHANNELS; j = j + 1)
				gain_db_out[8*j +: 8] <= gain_db(gain_reg[3*j +: 3]);
		end
	end
endmodule // adc_decimator
`default_nettype wire

/* File: verilog/adc_fifo.v */
`timescale 1ns/1ps
`default_nettype none
module adc_fifo #(
	parameter WIDTH = 19,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             clock_in,
	input  wire             reset_n_in,
	input  wire             in_valid_in,
	output wire             in_ready_out,
	input  wire [WIDTH-1:0] in_data_in,
	output wire             out_valid_out,
	input  wire             out_ready_in,
	output wire [WIDTH-1:0] out_data_out
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;
	wire            do_wr;
	wire            do_rd;
	assign in_ready_out  = (count != DEPTH[AW:0]);
	assign out_valid_out = (count != {(AW+1){1'b0}});
	assign out_data_out  = mem[rd_ptr];
	assign do_wr = in_valid_in & in_ready_out;
	assign do_rd = out_valid_out & out_ready_in;
	always @(posedge clock_in) begin
		if (do_wr)
			mem[wr_ptr] <= in_data_in;
	end
	always @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end else begin
			if (do_wr)
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			if (do_rd)
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			if (do_wr & ~do_rd)
				count <= count + 1'b1;
			else if (do_rd & ~do_wr)
				count <= count - 1'b1;
		end
	end
endmodule // adc_fifo
`default_nettype wire
